// ### hrt_pkg.sv
/*
 * Shared constants of the hibernation real-time clock block: register byte
 * offsets, field positions, reset values and the time-source figures.
 * Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
 */
`default_nettype none

package hrt_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;                // Decoded address bits
    localparam logic [7:0] OFS_CTRL = 8'h00;           // Enables
    localparam logic [7:0] OFS_SECONDS = 8'h04;        // Seconds counter
    localparam logic [7:0] OFS_SUBSEC = 8'h08;         // Sub-second count, read only
    localparam logic [7:0] OFS_MATCH0 = 8'h0C;         // Seconds match, index zero
    localparam logic [7:0] OFS_SSMATCH0 = 8'h10;       // Sub-second match, index zero
    localparam logic [7:0] OFS_TRIM = 8'h14;           // Pre-divider trim
    localparam logic [7:0] OFS_TSTAT = 8'h18;          // Tamper and match status
    localparam logic [7:0] OFS_LOG_BASE = 8'h40;       // Log window, 8 bytes per entry
    localparam logic [7:0] OFS_LOG_END = 8'h60;        // First byte past the log

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RTC_EN = 0;           // Counter running
    localparam int unsigned CTRL_INT_EN = 1;           // Match raises interrupt
    localparam int unsigned CTRL_WAKE_EN = 2;          // Match raises wake
    localparam int unsigned CTRL_TAMP_EN = 3;          // Tamper feature running
    localparam int unsigned TSTAT_STATE = 0;           // Event state; write 1 clears all
    localparam int unsigned TSTAT_MATCH = 1;           // Live match equality
    localparam int unsigned TSTAT_CNT_LSB = 4;         // Logged entry count

    // ------------------------------------------------------------
    // Widths, reset values and time figures
    // ------------------------------------------------------------
    localparam int unsigned SUBSEC_W = 15;             // 1/32768 s unit
    localparam int unsigned TRIM_W = 16;               // Trim and pre-divider width
    localparam logic [15:0] TRIM_RST = 16'h7FFF;       // Nominal trim
    localparam logic [15:0] PDIV_TOP = 16'h7FFF;       // Untrimmed last count
    localparam int unsigned SRC_HZ = 32768;            // Time source rate
    localparam int unsigned TRIM_EVERY_S = 64;         // Seconds between trim loads
    localparam int unsigned TRIM_LOG2 = $clog2(TRIM_EVERY_S);
    localparam int unsigned LOG_DEPTH = 4;             // Tamper log entries
    localparam int unsigned EVT_W = 5;                 // Four inputs plus oscillator fail
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : hrt_pkg

`default_nettype wire

// ### hrt_sync3.sv
/*
 * Three-stage synchroniser for a group of pin inputs. A bit's output moves
 * only once the second and third stages agree.
 * Assumes inputs asynchronous to sys_clk_i; no relation between the bits.
 */
`timescale 1ns/1ps
`default_nettype none

module hrt_sync3 #(
    parameter int unsigned W = 1                       // Number of bits
) (
    input wire logic sys_clk_i,                        // System clock
    input wire logic reset_n_i,                        // Async reset, active low
    input wire logic [W-1:0] d_i,                      // Raw pin levels
    output logic [W-1:0] q_o                           // Filtered levels
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] ff1;                             // Metastable stage, read by ff2 only
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] q;                               // Agreed level
    } hrt_sync_s;

    hrt_sync_s s_r;
    hrt_sync_s s_nxt;

    initial begin
        if (W < 1) $error("hrt_sync3: W must be at least 1");
    end

    // Next state: shift, then accept bits whose last two stages agree
    always_comb begin
        s_nxt = s_r;
        s_nxt.ff1 = d_i;
        s_nxt.ff2 = s_r.ff1;
        s_nxt.ff3 = s_r.ff2;
        for (int i = 0; i < int'(W); i++) begin
            if (s_r.ff2[i] == s_r.ff3[i]) begin
                s_nxt.q[i] = s_r.ff3[i];
            end
        end
    end

    // Register the whole state
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.q;

endmodule : hrt_sync3

`default_nettype wire

// ### hrt_top.sv
/*
 * Real-time clock of the hibernation unit: seconds and sub-second counters
 * from a 32.768 kHz source through a trimmed pre-divider, seconds and
 * sub-second match with interrupt and wake pulses, tamper enable and a
 * four-entry tamper event log, all behind an AXI4-Lite slave.
 * Assumes the source and tamper pins are asynchronous and much slower than
 * sys_clk_i, and a reset that comes only from a hibernation-unit reset.
 */
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module hrt_top (
    input wire logic sys_clk_i,                        // 125 MHz system clock
    input wire logic reset_n_i,                        // Async reset, active low
    input wire logic src_32k_i,                        // 32.768 kHz time source pin
    input wire logic [hrt_pkg::EVT_W-1:0] tamper_evt_i, // Tamper event pins, active high
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic match_irq_o,                          // One-cycle match interrupt pulse
    output logic match_wake_o,                         // One-cycle match wake pulse
    output logic tamper_state_o                        // Tamper event state level
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [0:0] {WR_IDLE, WR_RESP} hrt_wr_e;

    typedef struct packed {
        logic [3:0] ctrl;                              // Enable bits
        logic [31:0] sec;                              // Seconds counter
        logic [hrt_pkg::TRIM_W-1:0] pdiv;              // Pre-divider count
        logic [31:0] match;                            // Seconds match
        logic [hrt_pkg::SUBSEC_W-1:0] ssmatch;         // Sub-second match
        logic [hrt_pkg::TRIM_W-1:0] trim;              // Trim value
        logic src_prev;                                // Last synced source level
        logic [hrt_pkg::EVT_W-1:0] evt_prev;           // Last synced tamper levels
        logic hit_prev;                                // Match equality last cycle
        logic irq;
        logic wake;
        logic tstate;                                  // Tamper event seen
        logic [2:0] lcnt;                              // Entries in use, 0 to 4
        logic [3:0][31:0] ltime;                       // Logged seconds
        logic [3:0][hrt_pkg::EVT_W-1:0] levt;          // Logged event bits
        logic aw_have;                                 // Write address held
        logic [7:0] aw_addr;
        logic w_have;                                  // Write data held
        logic [31:0] w_data;
        logic [3:0] w_strb;
        hrt_wr_e wst;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } hrt_state_s;

    hrt_state_s s_r;
    hrt_state_s s_nxt;

    logic src_s;                                       // Synced time source
    logic [hrt_pkg::EVT_W-1:0] evt_s;                  // Synced tamper pins

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    hrt_sync3 #(
        .W(hrt_pkg::EVT_W + 1)
    ) i_hrt_sync3 (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .d_i({tamper_evt_i, src_32k_i}),
        .q_o({evt_s, src_s})
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // True for any mapped offset; used by the read path only
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a[1:0] == 2'b00) && ((a <= hrt_pkg::OFS_TSTAT) ||
                  ((a >= hrt_pkg::OFS_LOG_BASE) && (a < hrt_pkg::OFS_LOG_END)));
    endfunction : reg_hit

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction : merge

    // Sub-second view: saturates while a raised trim runs the divider past 0x7FFF
    logic [hrt_pkg::SUBSEC_W-1:0] subsec;
    assign subsec = s_r.pdiv[hrt_pkg::SUBSEC_W] ? hrt_pkg::PDIV_TOP[hrt_pkg::SUBSEC_W-1:0]
                                                : s_r.pdiv[hrt_pkg::SUBSEC_W-1:0];

    logic hit;                                         // Both counters equal their match
    logic tick;                                        // One source rising edge
    logic [hrt_pkg::TRIM_W-1:0] top;                   // Last divider count this second
    logic [hrt_pkg::EVT_W-1:0] evt_rise;
    logic wr_now;                                      // Register write this cycle
    assign hit = s_r.ctrl[hrt_pkg::CTRL_RTC_EN] && (s_r.sec == s_r.match) &&
                 (subsec == s_r.ssmatch);
    assign tick = src_s && !s_r.src_prev;
    assign top = (s_r.sec[hrt_pkg::TRIM_LOG2-1:0] == '0) ? s_r.trim : hrt_pkg::PDIV_TOP;
    assign evt_rise = evt_s & ~s_r.evt_prev;
    assign wr_now = s_r.aw_have && s_r.w_have && (s_r.wst == WR_IDLE);

    // Read word for an offset; reserved bits and match indices above zero are absent
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [1:0] idx;
        idx = a[4:3];
        rd_word = '0;
        case (a)
            hrt_pkg::OFS_CTRL: rd_word[3:0] = s_r.ctrl;
            hrt_pkg::OFS_SECONDS: rd_word = s_r.sec;
            hrt_pkg::OFS_SUBSEC: rd_word[hrt_pkg::SUBSEC_W-1:0] = subsec;
            hrt_pkg::OFS_MATCH0: rd_word = s_r.match;
            hrt_pkg::OFS_SSMATCH0: rd_word[hrt_pkg::SUBSEC_W-1:0] = s_r.ssmatch;
            hrt_pkg::OFS_TRIM: rd_word[hrt_pkg::TRIM_W-1:0] = s_r.trim;
            hrt_pkg::OFS_TSTAT: begin
                rd_word[hrt_pkg::TSTAT_STATE] = s_r.tstate;
                rd_word[hrt_pkg::TSTAT_MATCH] = hit;
                rd_word[hrt_pkg::TSTAT_CNT_LSB +: 3] = s_r.lcnt;
            end
            // Log window: even word time, odd word event; read leaves it intact
            default: rd_word = a[2] ? 32'(s_r.levt[idx]) : s_r.ltime[idx];
        endcase
    endfunction : rd_word

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic clr;
        logic sec_wr;
        logic [31:0] wv;
        logic [2:0] slot;
        clr = 1'b0;
        sec_wr = 1'b0;
        wv = '0;
        slot = '0;
        s_nxt = s_r;
        s_nxt.src_prev = src_s;
        s_nxt.evt_prev = evt_s;
        s_nxt.hit_prev = hit;

        // Address and data are taken independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end

        // Register write once both halves are held
        if (wr_now) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.wst = WR_RESP;
            s_nxt.bresp = hrt_pkg::RESP_OKAY;
            case (s_r.aw_addr)
                hrt_pkg::OFS_CTRL: begin
                    // All four enable bits take the write; log and state stay put
                    wv = merge({28'h0000000, s_r.ctrl}, s_r.w_data, s_r.w_strb);
                    s_nxt.ctrl = wv[3:0];
                end
                hrt_pkg::OFS_SECONDS: begin
                    s_nxt.sec = merge(s_r.sec, s_r.w_data, s_r.w_strb);
                    sec_wr = 1'b1;
                end
                hrt_pkg::OFS_MATCH0: s_nxt.match = merge(s_r.match, s_r.w_data, s_r.w_strb);
                hrt_pkg::OFS_SSMATCH0: begin
                    wv = merge({17'h00000, s_r.ssmatch}, s_r.w_data, s_r.w_strb);
                    s_nxt.ssmatch = wv[hrt_pkg::SUBSEC_W-1:0];
                end
                hrt_pkg::OFS_TRIM: begin
                    wv = merge({16'h0000, s_r.trim}, s_r.w_data, s_r.w_strb);
                    s_nxt.trim = wv[hrt_pkg::TRIM_W-1:0];
                end
                hrt_pkg::OFS_TSTAT: clr = s_r.w_strb[0] && s_r.w_data[hrt_pkg::TSTAT_STATE];
                default: s_nxt.bresp = hrt_pkg::RESP_SLVERR; // Read-only or unmapped
            endcase
        end
        if ((s_r.wst == WR_RESP) && s_axi_bready) begin
            s_nxt.wst = WR_IDLE;
        end

        // Read path: one read at a time, answered the cycle after it is taken
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = reg_hit(s_axi_araddr) ? rd_word(s_axi_araddr) : 32'h00000000;
            s_nxt.rresp = reg_hit(s_axi_araddr) ? hrt_pkg::RESP_OKAY : hrt_pkg::RESP_SLVERR;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Counters: a seconds write restarts the divider at zero
        if (sec_wr) begin
            s_nxt.pdiv = '0;
        end else if (s_r.ctrl[hrt_pkg::CTRL_RTC_EN] && tick) begin
            if (s_r.pdiv >= top) begin
                s_nxt.pdiv = '0;
                s_nxt.sec = s_r.sec + 32'h00000001;
            end else begin
                s_nxt.pdiv = s_r.pdiv + 16'h0001;
            end
        end

        // Match pulses on the first cycle of equality
        s_nxt.irq = hit && !s_r.hit_prev && s_r.ctrl[hrt_pkg::CTRL_INT_EN];
        s_nxt.wake = hit && !s_r.hit_prev && s_r.ctrl[hrt_pkg::CTRL_WAKE_EN];

        // Tamper clear first, so an event in the same cycle survives it
        if (clr) begin
            s_nxt.tstate = 1'b0;
            s_nxt.lcnt = '0;
            s_nxt.ltime = '0;
            s_nxt.levt = '0;
        end
        slot = clr ? 3'd0 : s_r.lcnt;
        if (s_r.ctrl[hrt_pkg::CTRL_TAMP_EN] && (evt_rise != '0)) begin
            s_nxt.tstate = 1'b1;
            // A full log keeps its first four entries
            if (slot < 3'(hrt_pkg::LOG_DEPTH)) begin
                s_nxt.ltime[slot[1:0]] = s_r.sec;
                s_nxt.levt[slot[1:0]] = evt_rise;
                s_nxt.lcnt = slot + 3'd1;
            end
        end
    end

    // Register the whole state
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
            s_r.trim <= hrt_pkg::TRIM_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !s_r.aw_have;
    assign s_axi_wready = !s_r.w_have;
    assign s_axi_bvalid = (s_r.wst == WR_RESP);
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign match_irq_o = s_r.irq;
    assign match_wake_o = s_r.wake;
    assign tamper_state_o = s_r.tstate;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_sec_step: assert property ((tick && s_r.ctrl[0] && s_r.pdiv >= top && !wr_now)
        |=> (s_r.sec == $past(s_r.sec) + 32'h00000001) && (s_r.pdiv == '0))
        else $error("seconds did not step at divider end");
    a_sub_wrap: assert property ((s_r.sec != $past(s_r.sec)) |-> (s_r.pdiv == '0))
        else $error("sub-second not zero after seconds change");
    a_sub_count: assert property ((tick && s_r.ctrl[0] && s_r.pdiv < top && !wr_now)
        |=> s_r.pdiv == $past(s_r.pdiv) + 16'h0001)
        else $error("sub-second did not advance");
    a_div_hold: assert property ((!tick && !wr_now) |=> $stable(s_r.sec) && $stable(s_r.pdiv))
        else $error("counters moved without a source edge");
    a_trim_top: assert property ((tick && s_r.ctrl[0] && !wr_now && s_r.sec[5:0] == 6'h00
        && s_r.pdiv >= s_r.trim) |=> s_r.sec == $past(s_r.sec) + 32'h00000001)
        else $error("trim not applied in the trimmed second");
    a_match_fire: assert property (match_irq_o || match_wake_o
        |-> $past(hit) && !$past(s_r.hit_prev))
        else $error("match pulse without fresh equality");
    a_match_both: assert property ((s_r.ctrl[0] && s_r.ctrl[1] && s_r.sec == s_r.match
        && subsec == s_r.ssmatch && !s_r.hit_prev) |=> match_irq_o)
        else $error("match of both counters raised no interrupt");
    a_bad_read: assert property ((s_axi_rvalid && s_axi_rresp == hrt_pkg::RESP_SLVERR)
        |-> s_axi_rdata == 32'h00000000)
        else $error("reserved read returned data");
    a_clear_all: assert property ((wr_now && s_r.aw_addr == hrt_pkg::OFS_TSTAT && s_r.w_strb[0]
        && s_r.w_data[0] && !s_r.ctrl[3]) |=> (s_r.lcnt == 3'd0) && !s_r.tstate)
        else $error("tamper clear left state or log");
    a_log_keep: assert property ((!wr_now && evt_rise == '0) |=> $stable(s_r.lcnt)
        && $stable(s_r.ltime) && $stable(s_r.tstate))
        else $error("log changed without event or clear");
    a_log_depth: assert property (s_r.lcnt <= 3'd4)
        else $error("log count above four");
    a_off_keep: assert property ($fell(s_r.ctrl[3]) |-> $stable(s_r.trim) && $stable(s_r.lcnt))
        else $error("tamper disable disturbed settings");

    c_second: cover property (tick && s_r.pdiv >= top && s_r.ctrl[0]);
    c_match: cover property (match_irq_o && match_wake_o);
    c_log_full: cover property (s_r.lcnt == 3'd4);
    c_clear: cover property ($fell(s_r.tstate));

endmodule : hrt_top

`default_nettype wire

// ### hrt_top_test.sv
/*
 * Self-checking bench for hrt_top: AXI4-Lite register tasks, time-source
 * ticks and tamper pin pulses, with expected values from the register map.
 * Assumes hrt_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module hrt_top_test;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic src = 1'b0;
    logic [4:0] evt = 5'h00;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    wire logic awready, wready, bvalid, arready, rvalid, irq, wake, tstate;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int fails = 0;
    int check_count = 0;
    int irq_n = 0;
    int wake_n = 0;

    hrt_top i_hrt_top (.sys_clk_i(clk), .reset_n_i(rst_n), .src_32k_i(src), .tamper_evt_i(evt),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .match_irq_o(irq), .match_wake_o(wake), .tamper_state_o(tstate));

    // Clock; pulses counted so one-cycle outputs are never missed
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq === 1'b1) irq_n++;
        if (wake === 1'b1) wake_n++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Readies are sampled at the falling edge, so the rising edge that follows takes the item
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                chk({30'h0, r}, {30'h0, er});
                return;
            end
        end
        fails++;
        end_sim();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = arvalid & arready;
            if (rvalid === 1'b1) begin
                chk(rdata, ed);
                chk({30'h0, rresp}, {30'h0, er});
            end
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                return;
            end
        end
        fails++;
        end_sim();
    endtask : rd

    // Source edges and tamper pulses wide enough for the synchronisers
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk) src <= 1'b1;
            repeat (6) @(posedge clk);
            src <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask : tick

    task automatic evp(input int b);
        @(posedge clk) evt[b] <= 1'b1;
        repeat (6) @(posedge clk);
        evt[b] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : evp

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(hrt_pkg::OFS_TRIM, {16'h0, hrt_pkg::TRIM_RST}, hrt_pkg::RESP_OKAY);
        rd(hrt_pkg::OFS_CTRL, 32'h0, hrt_pkg::RESP_OKAY);
        wr(hrt_pkg::OFS_TRIM, 32'h3, hrt_pkg::RESP_OKAY);
        rd(hrt_pkg::OFS_TRIM, 32'h3, hrt_pkg::RESP_OKAY);
        wr(8'h1C, 32'h5, hrt_pkg::RESP_SLVERR);
        rd(8'h1C, 32'h0, hrt_pkg::RESP_SLVERR);
        // Match set before enabling, so the all-zero equality after reset never fires
        wr(hrt_pkg::OFS_MATCH0, 32'h41, hrt_pkg::RESP_OKAY);
        wr(hrt_pkg::OFS_SSMATCH0, 32'h1, hrt_pkg::RESP_OKAY);
        wr(hrt_pkg::OFS_CTRL, 32'h7, hrt_pkg::RESP_OKAY);
        // Second 0x40 uses the short trimmed count of four source edges
        wr(hrt_pkg::OFS_SECONDS, 32'h40, hrt_pkg::RESP_OKAY);
        tick(2);
        rd(hrt_pkg::OFS_SUBSEC, 32'h2, hrt_pkg::RESP_OKAY);
        tick(2);
        rd(hrt_pkg::OFS_SECONDS, 32'h41, hrt_pkg::RESP_OKAY);
        rd(hrt_pkg::OFS_SUBSEC, 32'h0, hrt_pkg::RESP_OKAY);
        chk(irq_n, 0);
        tick(1);
        chk(irq_n, 1);
        chk(wake_n, 1);
        rd(hrt_pkg::OFS_TSTAT, 32'h2, hrt_pkg::RESP_OKAY);
        // Tamper log: one entry, disable, re-enable, fill, clear
        wr(hrt_pkg::OFS_CTRL, 32'h9, hrt_pkg::RESP_OKAY);
        evp(2);
        chk({31'h0, tstate}, 32'h1);
        rd(8'h40, 32'h41, hrt_pkg::RESP_OKAY);
        rd(8'h44, 32'h4, hrt_pkg::RESP_OKAY);
        rd(8'h44, 32'h4, hrt_pkg::RESP_OKAY);
        wr(hrt_pkg::OFS_CTRL, 32'h1, hrt_pkg::RESP_OKAY);
        evp(0);
        rd(hrt_pkg::OFS_TSTAT, 32'h13, hrt_pkg::RESP_OKAY);
        wr(hrt_pkg::OFS_CTRL, 32'h9, hrt_pkg::RESP_OKAY);
        evp(1);
        evp(3);
        evp(4);
        evp(0);
        rd(hrt_pkg::OFS_TSTAT, 32'h43, hrt_pkg::RESP_OKAY);
        rd(8'h5C, 32'h10, hrt_pkg::RESP_OKAY);
        rd(hrt_pkg::OFS_LOG_END, 32'h0, hrt_pkg::RESP_SLVERR);
        wr(hrt_pkg::OFS_TSTAT, 32'h1, hrt_pkg::RESP_OKAY);
        rd(hrt_pkg::OFS_TSTAT, 32'h2, hrt_pkg::RESP_OKAY);
        chk({31'h0, tstate}, 32'h0);
        end_sim();
    end
endmodule : hrt_top_test

`default_nettype wire
